// file: design/sfr_defs.svh
// Constants for the serial flash register command block.
// Assumes a 20 MHz system clock and a host that frames every
// transfer with an active-low select.
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

// ==========================================================
// Command codes
`define SFR_CMD_WREN 8'h06
`define SFR_CMD_WRDIS 8'h04
`define SFR_CMD_CLR_FLAG 8'h50
`define SFR_CMD_RD_STATUS 8'h05
`define SFR_CMD_RD_FLAG 8'h70
`define SFR_CMD_RD_NVCFG 8'hb5
`define SFR_CMD_RD_VCFG 8'h85
`define SFR_CMD_RD_EVCFG 8'h65
`define SFR_CMD_RD_EXT 8'hc8
`define SFR_CMD_WR_STATUS 8'h01
`define SFR_CMD_WR_NVCFG 8'hb1
`define SFR_CMD_WR_VCFG 8'h81
`define SFR_CMD_WR_EVCFG 8'h61
`define SFR_CMD_WR_EXT 8'hc5
`define SFR_CMD_WORD_READ 8'he7
`define SFR_CMD_DTR_READ 8'h0d
`define SFR_CMD_DTR_QIO_READ 8'hed

// ==========================================================
// Frame lengths in bits, field positions
`define SFR_BITS_CMD 8'h08
`define SFR_BITS_ONE 8'h10
`define SFR_BITS_TWO 8'h18
`define SFR_ST_WIP 0
`define SFR_ST_WEL 1
`define SFR_FL_READY 7
`define SFR_FL_ERASE 5
`define SFR_FL_PROG 4
`define SFR_FL_PROT 1
`define SFR_EV_QUAD_N 7
`define SFR_EV_DUAL_N 6
`define SFR_NV_ADDR3 0
`define SFR_WORD_DUMMY 4'h4

// ==========================================================
// Reset values and reserved-bit masks
`define SFR_RST_STATUS 8'h00
`define SFR_RST_FLAG 8'h80
`define SFR_RST_NVCFG 16'hffff
`define SFR_RST_VCFG 8'hfb
`define SFR_RST_EVCFG 8'hff
`define SFR_RST_EXT 8'h00
`define SFR_RSVD_NVCFG 16'h0020
`define SFR_RSVD_VCFG 8'h04
`define SFR_RSVD_EVCFG 8'h10
`define SFR_RSVD_EXT 8'hfe

// ==========================================================
// Timing
`define SFR_CLOCK_PERIOD_NS 50
`define SFR_STATUS_WRITE_TIME_NS 1000000
`define SFR_NVCFG_WRITE_TIME_NS 2000000
`define SFR_STATUS_WRITE_CYCLES ((`SFR_STATUS_WRITE_TIME_NS + \
    `SFR_CLOCK_PERIOD_NS - 1) / `SFR_CLOCK_PERIOD_NS)
`define SFR_NVCFG_WRITE_CYCLES ((`SFR_NVCFG_WRITE_TIME_NS + \
    `SFR_CLOCK_PERIOD_NS - 1) / `SFR_CLOCK_PERIOD_NS)

`endif

// file: design/sfr_link.sv
// Link end: shifts command and data bits on the serial clock and
// drives register read data back on the lanes.
// Assumes select is high whenever the serial clock may glitch.
`timescale 1ns/10ps
`include "sfr_defs.svh"

module sfr_link (
    // Link clock and select.
    input wire logic sclk,
    input wire logic csN,
    // Data lanes.
    input wire logic [3:0] dqIn,
    output logic [3:0] dqOut,
    output logic [3:0] dqOe,
    // Core side.
    sfr_link_if.link lk
);
    import sfr_pkg::*;

    sfr_proto_t proto;
    logic [7:0] step;
    logic [7:0] next_cnt;
    logic [23:0] next_sh;
    logic [7:0] outPos;
    logic [7:0] nvByte;
    logic [7:0] rdByte;
    logic [7:0] rdShift;
    logic isRead;
    logic inFrame;
    logic [7:0] curCnt;
    logic [23:0] curSh;
    logic curBeyond;

    // ==========================================================
    // Input shifting
    // Lane count follows the snapshot protocol for every phase.
    assign proto = sfr_proto(lk.pub.evcfg);
    assign step = (proto == SFR_QUAD) ? 8'h04 :
        (proto == SFR_DUAL) ? 8'h02 : 8'h01;
    // The first edge of a frame starts from zero; a cut frame is dropped.
    assign curCnt = inFrame ? lk.cnt : 8'h00;
    assign curSh = inFrame ? lk.sh : 24'h000000;
    assign curBeyond = inFrame && lk.beyond;
    assign next_cnt = curCnt + step;
    assign next_sh = (proto == SFR_QUAD) ? {curSh[19:0], dqIn} :
        (proto == SFR_DUAL) ? {curSh[21:0], dqIn[1:0]} :
        {curSh[22:0], dqIn[0]};

    // Select high marks the next clock edge as a frame start.
    always_ff @(posedge sclk or posedge csN) begin
        if (csN)
            inFrame <= 1'b0;
        else
            inFrame <= 1'b1;
    end

    // The capture is held after select rises, as the core reads it
    // only once select has passed its synchroniser.
    always_ff @(posedge sclk) begin
        lk.cnt <= next_cnt;
        lk.sh <= next_sh;
        lk.beyond <= curBeyond || next_cnt > `SFR_BITS_TWO;
        if (next_cnt == `SFR_BITS_CMD && !curBeyond)
            lk.cmd <= next_sh[7:0];
    end

    // ==========================================================
    // Read data selection
    // Each read only sees the snapshot taken before the frame began.
    assign outPos = lk.cnt - `SFR_BITS_CMD;
    assign nvByte = (lk.beyond || outPos >= 8'h10) ? 8'h00 :
        (outPos < 8'h08) ? lk.pub.nvcfg[7:0] :
        lk.pub.nvcfg[15:8];
    assign rdByte =
        (lk.cmd == `SFR_CMD_RD_STATUS) ? lk.pub.status :
        (lk.cmd == `SFR_CMD_RD_FLAG) ? lk.pub.flag :
        (lk.cmd == `SFR_CMD_RD_NVCFG) ? nvByte :
        (lk.cmd == `SFR_CMD_RD_VCFG) ? lk.pub.vcfg :
        (lk.cmd == `SFR_CMD_RD_EVCFG) ? lk.pub.evcfg :
        lk.pub.ext;
    assign isRead = (lk.cnt >= `SFR_BITS_CMD) && (
        lk.cmd == `SFR_CMD_RD_STATUS || lk.cmd == `SFR_CMD_RD_FLAG ||
        lk.cmd == `SFR_CMD_RD_NVCFG || lk.cmd == `SFR_CMD_RD_VCFG ||
        lk.cmd == `SFR_CMD_RD_EVCFG || lk.cmd == `SFR_CMD_RD_EXT);
    assign rdShift = rdByte << outPos[2:0];

    // Output changes on the falling edge, half a period before use.
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            dqOut <= 4'h0;
            dqOe <= 4'h0;
        end else if (!isRead) begin
            dqOut <= 4'h0;
            dqOe <= 4'h0;
        end else if (proto == SFR_QUAD) begin
            dqOut <= rdShift[7:4];
            dqOe <= 4'hf;
        end else if (proto == SFR_DUAL) begin
            dqOut <= {2'h0, rdShift[7:6]};
            dqOe <= 4'h3;
        end else begin
            dqOut <= {2'h0, rdShift[7], 1'b0};
            dqOe <= 4'h2;
        end
    end
endmodule : sfr_link

// file: design/sfr_link_if.sv
// Carrier between the system-clock core and the link-clock end.
// Assumes the core drives the register snapshot only while select
// is high, and the link end holds its capture while the clock stops.
`timescale 1ns/10ps

interface sfr_link_if;
    import sfr_pkg::*;
    sfr_regs_t pub;
    logic [7:0] cnt;
    logic [23:0] sh;
    logic [7:0] cmd;
    logic beyond;

    modport core (output pub, input cnt, input sh, input cmd,
        input beyond);
    modport link (input pub, output cnt, output sh, output cmd,
        output beyond);
endinterface : sfr_link_if

// file: design/sfr_pkg.sv
// Types shared by the register command core and its link end.
// Assumes sfr_defs.svh is on the include path.
`include "sfr_defs.svh"

package sfr_pkg;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SFR_EXT = 2'h0,
        SFR_DUAL = 2'h1,
        SFR_QUAD = 2'h2
    } sfr_proto_t;

    typedef enum logic [1:0] {
        SFR_IDLE = 2'h0,
        SFR_WRITING = 2'h1,
        SFR_FINISH = 2'h3
    } sfr_state_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] flag;
        logic [15:0] nvcfg;
        logic [7:0] vcfg;
        logic [7:0] evcfg;
        logic [7:0] ext;
    } sfr_regs_t;

    // Lane protocol from the enhanced volatile register; quad wins.
    function automatic sfr_proto_t sfr_proto(input logic [7:0] ev);
        if (!ev[`SFR_EV_QUAD_N])
            return SFR_QUAD;
        if (!ev[`SFR_EV_DUAL_N])
            return SFR_DUAL;
        return SFR_EXT;
    endfunction : sfr_proto

endpackage : sfr_pkg

// file: design/sfr_register_cmds.sv
// Register command core of a serial flash: latch, status, flag
// status, configuration registers and self-timed register writes.
// Assumes error events come from logic on the same system clock
// and that the host leaves select high for three system clocks
// between frames, so the register snapshot settles.
`timescale 1ns/10ps
`include "sfr_defs.svh"

module sfr_register_cmds #(
    parameter int unsigned STATUS_WRITE_CYCLES =
        `SFR_STATUS_WRITE_CYCLES,
    parameter int unsigned NVCFG_WRITE_CYCLES = `SFR_NVCFG_WRITE_CYCLES
) (
    // System clock, reset and enable.
    input wire logic clock,
    input wire logic nrst,
    input wire logic clkEn,
    // Link pins.
    input wire logic sclk,
    input wire logic csN,
    input wire logic [3:0] dqIn,
    output logic [3:0] dqOut,
    output logic [3:0] dqOe,
    // Error events: erase, program, protection.
    input wire logic [2:0] errSet,
    // Register views and address phase information.
    output sfr_pkg::sfr_regs_t regs,
    output logic [5:0] addrCycles,
    output logic [3:0] dummyCycles
);
    import sfr_pkg::*;

    localparam int ERR_POS [3] = '{`SFR_FL_PROT, `SFR_FL_PROG,
        `SFR_FL_ERASE};

    sfr_link_if lk ();

    logic csS1;
    logic csS2;
    logic csLast;
    logic frameEnd;
    logic cmdOnly;
    logic oneByte;
    logic twoByte;
    logic [7:0] cmd;
    logic [7:0] dataByte;
    logic [15:0] dataWord;
    logic wel;
    logic busy;
    logic protErr;
    logic doWren;
    logic doWrdis;
    logic doClrFlag;
    logic doWrStatus;
    logic doWrNv;
    logic doWrV;
    logic doWrEv;
    logic doWrExt;
    sfr_state_t state;
    sfr_state_t next_state;
    logic [24:0] timer;
    logic [24:0] next_timer;
    logic pendNv;
    logic [15:0] pendWord;
    logic next_wel;
    logic [7:0] next_flag;
    sfr_proto_t proto;
    logic [5:0] addrBits;

    // Address phase cycles for the double-rate and word reads.
    function automatic logic [5:0] addr_phase(input logic [7:0] c,
            input sfr_proto_t p, input logic [5:0] ab);
        logic [5:0] r;
        r = 6'h00;
        case (c)
            `SFR_CMD_WORD_READ: begin
                if (p == SFR_EXT)
                    r = 6'h07 + (ab >> 2);
                else if (p == SFR_QUAD)
                    r = 6'h01 + (ab >> 2);
            end
            `SFR_CMD_DTR_READ: begin
                if (p == SFR_EXT)
                    r = 6'h07 + (ab >> 1);
                else if (p == SFR_DUAL)
                    r = 6'h03 + (ab >> 2);
                else
                    r = 6'h01 + (ab >> 3);
            end
            `SFR_CMD_DTR_QIO_READ: begin
                if (p == SFR_EXT)
                    r = 6'h07 + (ab >> 3);
                else if (p == SFR_QUAD)
                    r = 6'h01 + (ab >> 3);
            end
            default: begin
                r = 6'h00;
            end
        endcase
        return r;
    endfunction : addr_phase

    // ==========================================================
    // Link end
    sfr_link u_link (
        .sclk(sclk),
        .csN(csN),
        .dqIn(dqIn),
        .dqOut(dqOut),
        .dqOe(dqOe),
        .lk(lk.link)
    );

    // ==========================================================
    // Select synchroniser and frame end
    // Select comes from the host's domain, so it passes two stages.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            csS1 <= 1'b1;
            csS2 <= 1'b1;
            csLast <= 1'b1;
        end else if (clkEn) begin
            csS1 <= csN;
            csS2 <= csS1;
            csLast <= csS2;
        end
    end

    // The link capture is read only after select is seen high; the
    // serial clock has stopped by then, so the words are stable.
    assign frameEnd = clkEn && csS2 && !csLast;
    assign cmd = lk.cmd;
    assign dataByte = lk.sh[7:0];
    assign dataWord = {lk.sh[7:0], lk.sh[15:8]};
    assign cmdOnly = frameEnd && !lk.beyond &&
        lk.cnt == `SFR_BITS_CMD;
    assign oneByte = frameEnd && !lk.beyond &&
        lk.cnt == `SFR_BITS_ONE;
    assign twoByte = frameEnd && !lk.beyond &&
        lk.cnt == `SFR_BITS_TWO;

    // ==========================================================
    // Command decode
    assign wel = regs.status[`SFR_ST_WEL];
    assign busy = state != SFR_IDLE;
    assign protErr = regs.flag[`SFR_FL_PROT];
    assign doWren = cmdOnly && cmd == `SFR_CMD_WREN;
    assign doWrdis = cmdOnly && cmd == `SFR_CMD_WRDIS &&
        !protErr;
    assign doClrFlag = cmdOnly && cmd == `SFR_CMD_CLR_FLAG;
    assign doWrStatus = oneByte && cmd == `SFR_CMD_WR_STATUS &&
        wel && !busy;
    assign doWrNv = twoByte && cmd == `SFR_CMD_WR_NVCFG &&
        wel && !busy;
    assign doWrV = oneByte && cmd == `SFR_CMD_WR_VCFG && wel;
    assign doWrEv = oneByte && cmd == `SFR_CMD_WR_EVCFG && wel;
    assign doWrExt = oneByte && cmd == `SFR_CMD_WR_EXT && wel;

    // ==========================================================
    // Self-timed write sequencer
    // Only one timed write at a time; others are refused while busy.
    always_comb begin
        next_state = state;
        next_timer = timer;
        case (state)
            SFR_IDLE: begin
                if (doWrStatus) begin
                    next_state = SFR_WRITING;
                    next_timer = 25'(STATUS_WRITE_CYCLES - 1);
                end else if (doWrNv) begin
                    next_state = SFR_WRITING;
                    next_timer = 25'(NVCFG_WRITE_CYCLES - 1);
                end
            end
            SFR_WRITING: begin
                if (timer == 25'h0000000)
                    next_state = SFR_FINISH;
                else
                    next_timer = timer - 25'h0000001;
            end
            SFR_FINISH: begin
                next_state = SFR_IDLE;
            end
            default: begin
                next_state = SFR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= SFR_IDLE;
            timer <= 25'h0000000;
        end else if (clkEn) begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // Pending value is committed when the timed write finishes.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pendNv <= 1'b0;
            pendWord <= 16'h0000;
        end else if (doWrStatus || doWrNv) begin
            pendNv <= doWrNv;
            pendWord <= doWrNv ? (dataWord | `SFR_RSVD_NVCFG) :
                {8'h00, dataByte};
        end
    end

    // ==========================================================
    // Latch and flag status
    // The finish step clears the latch even if the write failed.
    assign next_wel = doWren ? 1'b1 :
        (doWrdis || doClrFlag || state == SFR_FINISH) ? 1'b0 :
        wel;

    // Error events win over a clear arriving in the same cycle.
    always_comb begin
        next_flag = regs.flag;
        next_flag[`SFR_FL_READY] = next_state == SFR_IDLE;
        for (int i = 0; i < 3; i++) begin
            next_flag[ERR_POS[i]] = errSet[i] ||
                (regs.flag[ERR_POS[i]] && !doClrFlag);
        end
    end

    // ==========================================================
    // Register file
    always_ff @(posedge clock) begin
        if (!nrst) begin
            regs.status <= `SFR_RST_STATUS;
            regs.flag <= `SFR_RST_FLAG;
        end else if (clkEn) begin
            regs.flag <= next_flag;
            regs.status[`SFR_ST_WEL] <= next_wel;
            regs.status[`SFR_ST_WIP] <= next_state != SFR_IDLE;
            if (state == SFR_FINISH && !pendNv)
                regs.status[7:2] <= pendWord[7:2];
        end
    end

    // Volatile registers change at once; reserved bits keep value.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            regs.nvcfg <= `SFR_RST_NVCFG;
            regs.vcfg <= `SFR_RST_VCFG;
            regs.evcfg <= `SFR_RST_EVCFG;
            regs.ext <= `SFR_RST_EXT;
        end else if (clkEn) begin
            if (state == SFR_FINISH && pendNv)
                regs.nvcfg <= pendWord;
            if (doWrV)
                regs.vcfg <= (dataByte & ~`SFR_RSVD_VCFG) |
                    (regs.vcfg & `SFR_RSVD_VCFG);
            if (doWrEv)
                regs.evcfg <= (dataByte & ~`SFR_RSVD_EVCFG) |
                    (regs.evcfg & `SFR_RSVD_EVCFG);
            if (doWrExt)
                regs.ext <= (dataByte & ~`SFR_RSVD_EXT) |
                    (regs.ext & `SFR_RSVD_EXT);
        end
    end

    // ==========================================================
    // Snapshot for the link end
    // Frozen while a frame runs: a read in progress sees one value,
    // at the cost of not seeing a write finish mid-frame.
    always_ff @(posedge clock) begin
        if (!nrst)
            lk.pub <= {`SFR_RST_STATUS, `SFR_RST_FLAG, `SFR_RST_NVCFG,
                `SFR_RST_VCFG, `SFR_RST_EVCFG, `SFR_RST_EXT};
        else if (clkEn && csS2)
            lk.pub <= regs;
    end

    // ==========================================================
    // Address phase report
    assign proto = sfr_proto(regs.evcfg);
    assign addrBits = regs.nvcfg[`SFR_NV_ADDR3] ? 6'h18 : 6'h20;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            addrCycles <= 6'h00;
            dummyCycles <= 4'h0;
        end else if (frameEnd && lk.cnt >= `SFR_BITS_CMD) begin
            addrCycles <= addr_phase(cmd, proto, addrBits);
            dummyCycles <= (cmd == `SFR_CMD_WORD_READ &&
                proto != SFR_DUAL) ? `SFR_WORD_DUMMY : 4'h0;
        end
    end
endmodule : sfr_register_cmds

// file: tb/sfr_assertions.sv
// Port-level checker for the register command core.
// Assumes the bench keeps the extended lane protocol throughout.
`timescale 1ns/10ps

module sfr_assertions #(
    parameter int unsigned STATUS_WRITE_CYCLES = 8,
    parameter int unsigned NVCFG_WRITE_CYCLES = 8
) (
    // System side.
    input wire logic clock,
    input wire logic nrst,
    input wire logic clkEn,
    // Link pins.
    input wire logic sclk,
    input wire logic csN,
    input wire logic [3:0] dqIn,
    input wire logic [3:0] dqOut,
    input wire logic [3:0] dqOe,
    // Events and register views.
    input wire logic [2:0] errSet,
    input wire sfr_pkg::sfr_regs_t regs,
    input wire logic [5:0] addrCycles,
    input wire logic [3:0] dummyCycles
);
    import sfr_pkg::*;

    // Length of the current in-progress stretch, frozen with the core.
    int unsigned wipRun;

    always_ff @(posedge clock) begin
        if (!nrst || !regs.status[0])
            wipRun <= 32'h00000000;
        else if (clkEn)
            wipRun <= wipRun + 32'h00000001;
    end

    // ==========================================================
    // Properties
    // One domain only, so clock and reset are given once.
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_lanes_released: assert property (
        csN && $past(csN) |-> dqOe == 4'h0)
        else $error("Lanes driven while deselected.");
    a_ext_lane_out: assert property (
        regs.evcfg[7:6] == 2'b11 && !csN && dqOe != 4'h0 |-> dqOe == 4'h2)
        else $error("Extended read not on lane one.");
    a_busy_not_ready: assert property (
        regs.status[0] |-> !regs.flag[7])
        else $error("Ready flag high during timed write.");
    a_finish_drops_latch: assert property (
        $fell(regs.status[0]) |-> !regs.status[1] && regs.flag[7])
        else $error("Latch still set after timed write.");
    a_write_lasts: assert property (
        $rose(regs.status[0]) |-> regs.status[0] [*8])
        else $error("Timed write ended too early.");
    a_write_length: assert property (
        $fell(regs.status[0]) |-> wipRun == STATUS_WRITE_CYCLES + 1 ||
        wipRun == NVCFG_WRITE_CYCLES + 1)
        else $error("Timed write length differs from its count.");
    a_status_at_end: assert property (
        $changed(regs.status[7:2]) |-> $fell(regs.status[0]))
        else $error("Status bits changed outside write finish.");
    a_nvcfg_at_end: assert property (
        $changed(regs.nvcfg) |-> $fell(regs.status[0]))
        else $error("Nonvolatile value changed outside finish.");
    a_reserved_kept: assert property (
        regs.nvcfg[5] && !regs.vcfg[2] && regs.evcfg[4]
        && regs.ext[7:1] == 7'h00)
        else $error("Reserved bit altered.");
    a_error_sets: assert property (
        errSet[0] && clkEn |=> regs.flag[1])
        else $error("Protection error not flagged.");
    a_dummy_value: assert property (
        dummyCycles == 4'h0 || dummyCycles == 4'h4)
        else $error("Unexpected dummy count.");

    // Main scenarios reached.
    c_write_done: cover property ($fell(regs.status[0]));
    c_read_out: cover property (dqOe == 4'h2);
    c_err_seen: cover property ($rose(regs.flag[1]));
endmodule : sfr_assertions

bind sfr_register_cmds sfr_assertions #(
    .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES),
    .NVCFG_WRITE_CYCLES(NVCFG_WRITE_CYCLES)
) i_sfr_assertions (.clock(clock), .nrst(nrst), .clkEn(clkEn),
    .sclk(sclk), .csN(csN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .errSet(errSet), .regs(regs), .addrCycles(addrCycles),
    .dummyCycles(dummyCycles));

// file: tb/sfr_host_model.sv
// Host controller model: frames commands in extended protocol.
// Assumes the bench leaves select high long enough between frames.
`timescale 1ns/10ps

module sfr_host_model (
    // Link pins driven by the host.
    output logic sclk,
    output logic csN,
    output logic [3:0] dqIn,
    // Device answer.
    input wire logic [3:0] dqOut,
    input wire logic [3:0] dqOe
);
    // The link clock stands still low outside frames.
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        dqIn = 4'h5;
    end

    // ==========================================================
    // Frame: nb bytes out on lane 0, then nr bytes in on lane 1.
    // The command goes whole, one lane, msb first.
    task automatic xfer(input logic [23:0] tx, input int nb,
        input int nr, output logic [23:0] rx);
        rx = 24'h0;
        csN = 1'b0;
        #6;
        for (int i = 0; i < nb * 8; i++) begin
            dqIn[0] = tx[23 - i];
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
        end
        for (int i = 0; i < nr * 8; i++) begin
            #6 sclk = 1'b1;
            rx = {rx[22:0], dqOut[1]};
            #6 sclk = 1'b0;
        end
        #6 csN = 1'b1;
        // Lanes are not held once released, so stale data cannot pass.
        dqIn = ~dqIn;
    endtask : xfer
endmodule : sfr_host_model

// file: tb/sfr_register_cmds_tb.sv
// Self-checking bench for the register command core.
// Assumes short timed-write counts and the extended lane protocol.
`timescale 1ns/10ps

module sfr_register_cmds_tb;
    import sfr_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic [2:0] errSet = 3'h0;
    wire logic sclk;
    wire logic csN;
    wire logic [3:0] dqIn;
    wire logic [3:0] dqOut;
    wire logic [3:0] dqOe;
    sfr_regs_t regs;
    logic [5:0] addrCycles;
    logic [3:0] dummyCycles;
    logic [23:0] rx;
    int num_errors = 0;
    int check_count = 0;

    // ==========================================================
    // Clock and instances
    always #25 clock = ~clock;

    sfr_register_cmds #(.STATUS_WRITE_CYCLES(20), .NVCFG_WRITE_CYCLES(30))
        i_sfr_register_cmds (.clock(clock), .nrst(nrst), .clkEn(clkEn),
        .sclk(sclk), .csN(csN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
        .errSet(errSet), .regs(regs), .addrCycles(addrCycles),
        .dummyCycles(dummyCycles));

    sfr_host_model i_sfr_host_model (.sclk(sclk), .csN(csN),
        .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Four system clocks after each frame let the core apply it.
    task automatic cmd(input logic [23:0] tx, input int nb, input int nr);
        i_sfr_host_model.xfer(tx, nb, nr, rx);
        repeat (4) @(negedge clock);
    endtask : cmd

    task automatic wait_wip(input logic v);
        int n;
        n = 0;
        while (regs.status[0] !== v && n < 100) begin
            @(negedge clock);
            n++;
        end
        chk(regs.status[0], v);
    endtask : wait_wip

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // ==========================================================
    // Scenarios
    task automatic t_latch;
        chk(regs, 56'h00_80_ffff_fb_ff_00);
        cmd({8'h06, 16'h0}, 1, 0);
        chk(regs.status[1], 1'b1);
        cmd({8'h04, 16'h0}, 1, 0);
        chk(regs.status[1], 1'b0);
        cmd({8'h06, 16'h0}, 2, 0);
        chk(regs.status[1], 1'b0);
        cmd({8'h06, 16'h0}, 1, 0);
    endtask : t_latch

    task automatic t_volatile;
        cmd({8'h81, 8'h0f, 8'h00}, 2, 0);
        chk(regs.vcfg, 8'h0b);
        cmd({8'h61, 8'he0, 8'h00}, 2, 0);
        chk(regs.evcfg, 8'hf0);
        cmd({8'hc5, 8'hff, 8'h00}, 2, 0);
        chk(regs.ext, 8'h01);
        chk(regs.status[1], 1'b1);
    endtask : t_volatile

    task automatic t_reads;
        logic [7:0] op [4] = '{8'h05, 8'h85, 8'h65, 8'hc8};
        logic [7:0] ex [4] = '{8'h02, 8'h0b, 8'hf0, 8'h01};
        for (int i = 0; i < 4; i++) begin
            cmd({op[i], 16'h0}, 1, 2);
            chk(rx[15:0], {ex[i], ex[i]});
        end
    endtask : t_reads

    task automatic t_status_write;
        cmd({8'h01, 8'h5c, 8'h00}, 3, 0);
        chk(regs.status, 8'h02);
        cmd({8'h01, 8'h5c, 8'h00}, 2, 0);
        chk(regs.status, 8'h03);
        cmd({8'h05, 16'h0}, 1, 1);
        chk(rx[7:0], 8'h03);
        wait_wip(1'b0);
        chk(regs.status, 8'h5c);
    endtask : t_status_write

    task automatic t_nvcfg;
        cmd({8'h06, 16'h0}, 1, 0);
        cmd({8'hb1, 8'h12, 8'h34}, 3, 0);
        wait_wip(1'b0);
        chk(regs.nvcfg, 16'h3432);
        chk(regs.status[1], 1'b0);
        cmd({8'hb5, 16'h0}, 1, 3);
        chk(rx, 24'h323400);
    endtask : t_nvcfg

    task automatic t_errors;
        @(posedge clock);
        clkEn <= 1'b0;
        errSet <= 3'h1;
        @(posedge clock);
        clkEn <= 1'b1;
        errSet <= 3'h0;
        @(negedge clock);
        chk(regs.flag, 8'h80);
        @(posedge clock);
        errSet <= 3'h7;
        @(posedge clock);
        errSet <= 3'h0;
        @(negedge clock);
        chk(regs.flag, 8'hb2);
        cmd({8'h06, 16'h0}, 1, 0);
        cmd({8'h04, 16'h0}, 1, 0);
        chk(regs.status[1], 1'b1);
        cmd({8'h50, 16'h0}, 1, 0);
        chk(regs.flag, 8'h80);
        chk(regs.status[1], 1'b0);
    endtask : t_errors

    // Thirty-two address bits now, as nonvolatile bit 0 is clear.
    task automatic t_addr;
        logic [7:0] op [3] = '{8'he7, 8'h0d, 8'hed};
        logic [5:0] ac [3] = '{6'd15, 6'd23, 6'd11};
        logic [3:0] dc [3] = '{4'h4, 4'h0, 4'h0};
        for (int i = 0; i < 3; i++) begin
            cmd({op[i], 16'h0}, 1, 0);
            chk(addrCycles, ac[i]);
            chk(dummyCycles, dc[i]);
        end
    endtask : t_addr

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(negedge clock);
        t_latch();
        t_volatile();
        t_reads();
        t_status_write();
        t_nvcfg();
        t_errors();
        t_addr();
        close_out();
    end

    initial begin
        #400000;
        num_errors++;
        close_out();
    end
endmodule : sfr_register_cmds_tb
